// ### ecx_defines.vh
// Purpose: constants of the move, increment, or and return execute block
// Assumes: 14-bit instruction word, 13-bit program counter
// Notes:   opcode values are local to this block
`ifndef ECX_DEFINES_VH
`define ECX_DEFINES_VH

// instruction field positions
`define ECX_OPC_MSB      13
`define ECX_OPC_LSB      8
`define ECX_DEST_BIT     7
`define ECX_FILE_MSB     6
`define ECX_LIT_MSB      7

// opcode field values
`define ECX_OPC_NOP      6'h00
`define ECX_OPC_STORE    6'h01
`define ECX_OPC_RETINT   6'h02
`define ECX_OPC_IOR      6'h04
`define ECX_OPC_COPY     6'h08
`define ECX_OPC_INC      6'h0A
`define ECX_OPC_LOADLIT  6'h30
`define ECX_OPC_RETLIT   6'h34

// operation select of the result unit
`define ECX_ALU_INC      2'h0
`define ECX_ALU_IOR      2'h1
`define ECX_ALU_COPY     2'h2

// reset values
`define ECX_RST_ACC      8'h00
`define ECX_RST_PC       13'h0000
`define ECX_RST_ZERO     1'b0
`define ECX_RST_GIE      1'b0

`endif

// ### ecx_alu.v
// Purpose: result and zero test for increment, inclusive or and copy
// Assumes: purely combinational, used by ecx_execute
// Notes:   zero reflects the result whatever the destination
`timescale 1ns/1ps
`default_nettype none
`include "ecx_defines.vh"

module ecx_alu (
  // operation
  input  wire [1:0] i_sel,
  // operands
  input  wire [7:0] i_acc,
  input  wire [7:0] i_file,
  // result
  output reg  [7:0] o_result,
  output wire       o_zero
);

  always @* begin
    if (i_sel == `ECX_ALU_INC) begin
      o_result = i_file + 8'h01;
    end else if (i_sel == `ECX_ALU_IOR) begin
      o_result = i_acc | i_file;
    end else begin
      o_result = i_file;
    end
  end

  assign o_zero = (o_result == 8'h00);

endmodule // ecx_alu
`default_nettype wire

// ### ecx_execute.v
// Purpose: execute stage for a subset of an 8-bit core instruction set
// Assumes: register file read data for the addressed register arrive
//          combinationally in the cycle an instruction is taken
// Notes:   returns spend one extra cycle with o_ready low
//          i_gie_clear comes from logic on this clock and is not synchronised
//          write address follows every take, write data only increment, or, copy and store; only o_file_we qualifies them
//          opcodes outside the supported set behave as no operation
//
// Function
// RULE1 - Increment adds one to the file register and writes it to the accumulator if dest is 0, else back to the register.
// RULE2 - Inclusive or combines accumulator and file register, writes by dest and updates the zero flag.
// RULE3 - Copy moves the file register to the accumulator if dest is 0, else rewrites the register with itself.
// RULE4 - Copy updates the zero flag from the moved value even when the register is the destination.
// RULE5 - Load literal puts the 8-bit immediate into the accumulator and leaves every flag alone.
// RULE6 - Store accumulator writes the accumulator into the addressed register (0 to 127) and leaves every flag alone.
// RULE7 - Return from interrupt pops the stack top into the program counter and sets global interrupt enable.
// RULE8 - Return with literal loads the accumulator with the immediate and the program counter from the stack top.
// RULE9 - Return with literal takes two instruction cycles.
// RULE10 - Return from interrupt also takes two instruction cycles.
// RULE11 - No operation takes one cycle and only advances the program counter.
`timescale 1ns/1ps
`default_nettype none
`include "ecx_defines.vh"

module ecx_execute (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst_b,
  // instruction
  input  wire        i_instr_valid,
  input  wire [13:0] i_instr,
  output wire        o_ready,
  // register file
  input  wire [7:0]  i_file_rdata,
  output wire [6:0]  o_file_raddr,
  output reg         o_file_we,
  output reg  [6:0]  o_file_waddr,
  output reg  [7:0]  o_file_wdata,
  // hardware stack
  input  wire [12:0] i_stack_top,
  output reg         o_stack_pop,
  // interrupt enable
  input  wire        i_gie_clear,
  output reg         o_gie,
  // core state
  output reg  [7:0]  o_acc,
  output reg         o_zero,
  output reg  [12:0] o_pc,
  output reg         o_done
);

  localparam ST_RUN   = 1'b0;
  localparam ST_FLUSH = 1'b1;

  // state and next-state values
  reg        state;
  reg        next_state;
  reg  [7:0] next_acc;
  reg        next_zero;
  reg [12:0] next_pc;
  reg        next_we;
  reg  [7:0] next_wdata;
  reg        next_pop;
  reg        next_gie_set;
  reg  [1:0] alu_sel;

  // instruction fields and decode
  wire [5:0] opc;
  wire       dest;
  wire [6:0] faddr;
  wire [7:0] literal;
  wire       take;
  wire [7:0] alu_result;
  wire       alu_zero;
  wire       is_inc;
  wire       is_ior;
  wire       is_retint;
  wire       is_retlit;
  wire       is_return;

  assign opc          = i_instr[`ECX_OPC_MSB:`ECX_OPC_LSB];
  assign dest         = i_instr[`ECX_DEST_BIT];
  assign faddr        = i_instr[`ECX_FILE_MSB:0];
  assign literal      = i_instr[`ECX_LIT_MSB:0];
  assign o_ready      = (state == ST_RUN);
  assign take         = i_instr_valid && o_ready;
  assign o_file_raddr = faddr;

  // opcode decode
  assign is_inc       = (opc == `ECX_OPC_INC);
  assign is_ior       = (opc == `ECX_OPC_IOR);
  assign is_retint    = (opc == `ECX_OPC_RETINT);
  assign is_retlit    = (opc == `ECX_OPC_RETLIT);
  assign is_return    = is_retint || is_retlit;

  always @* begin
    if (is_inc) begin
      alu_sel = `ECX_ALU_INC;
    end else if (is_ior) begin
      alu_sel = `ECX_ALU_IOR;
    end else begin
      alu_sel = `ECX_ALU_COPY;
    end
  end

  ecx_alu u_alu (
    .i_sel    (alu_sel),
    .i_acc    (o_acc),
    .i_file   (i_file_rdata),
    .o_result (alu_result),
    .o_zero   (alu_zero)
  );

  always @* begin
    next_state   = ST_RUN;
    next_acc     = o_acc;
    next_zero    = o_zero;
    next_pc      = o_pc;
    next_we      = 1'b0;
    next_wdata   = o_file_wdata;
    next_pop     = 1'b0;
    next_gie_set = 1'b0;
    if (take) begin
      next_pc = o_pc + 13'h0001;
      case (opc)
        `ECX_OPC_INC, `ECX_OPC_IOR, `ECX_OPC_COPY: begin
          // RULE1 RULE2 RULE3 dest select
          next_wdata = alu_result;
          if (dest) begin
            next_we = 1'b1;
          end else begin
            next_acc = alu_result;
          end
          // RULE2 RULE4 zero from result
          next_zero = alu_zero;
        end
        `ECX_OPC_LOADLIT: begin
          // RULE5 literal, flags kept
          next_acc = literal;
        end
        `ECX_OPC_STORE: begin
          // RULE6 accumulator to register
          next_we    = 1'b1;
          next_wdata = o_acc;
        end
        `ECX_OPC_RETINT: begin
          // RULE7 pop and enable
          next_pc      = i_stack_top;
          next_pop     = 1'b1;
          next_gie_set = 1'b1;
          // RULE10 second cycle
          next_state   = ST_FLUSH;
        end
        `ECX_OPC_RETLIT: begin
          // RULE8 literal and pop
          next_acc   = literal;
          next_pc    = i_stack_top;
          next_pop   = 1'b1;
          // RULE9 second cycle
          next_state = ST_FLUSH;
        end
        default: begin
          // RULE11 only pc advances
          next_pc = o_pc + 13'h0001;
        end
      endcase
    end
  end

  // core state registers
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state       <= ST_RUN;
      o_acc       <= `ECX_RST_ACC;
      o_zero      <= `ECX_RST_ZERO;
      o_pc        <= `ECX_RST_PC;
      o_stack_pop <= 1'b0;
    end else begin
      state       <= next_state;
      o_acc       <= next_acc;
      o_zero      <= next_zero;
      o_pc        <= next_pc;
      o_stack_pop <= next_pop;
    end
  end

  // register file write port
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_file_we    <= 1'b0;
      o_file_waddr <= 7'h00;
      o_file_wdata <= 8'h00;
    end else begin
      o_file_we <= next_we;
      if (take) begin
        o_file_waddr <= faddr;
        o_file_wdata <= next_wdata;
      end
    end
  end

  // RULE9 RULE10 returns finish late
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
    end else begin
      o_done <= (take && !is_return) || (state == ST_FLUSH);
    end
  end

  // RULE7 set wins over clear
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_gie <= `ECX_RST_GIE;
    end else if (next_gie_set) begin
      o_gie <= 1'b1;
    end else if (i_gie_clear) begin
      o_gie <= 1'b0;
    end
  end

endmodule // ecx_execute
`default_nettype wire

// ### ecx_monitor.sv
// Purpose: port checks of ecx_execute
// Assumes: one clock, reset active low
// Notes:   bound below
`timescale 1ns/1ps
`default_nettype none
module ecx_monitor (
  input wire        i_clk,
  input wire        i_rst_b,
  input wire        i_instr_valid,
  input wire [13:0] i_instr,
  input wire        o_ready,
  input wire [7:0]  i_file_rdata,
  input wire        o_file_we,
  input wire [7:0]  o_file_wdata,
  input wire [12:0] i_stack_top,
  input wire        o_stack_pop,
  input wire        o_gie,
  input wire [7:0]  o_acc,
  input wire        o_zero,
  input wire [12:0] o_pc,
  input wire        o_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire       tk = i_instr_valid & o_ready;
  wire [5:0] op = i_instr[13:8];
  sequence s_flush; !o_ready && !o_done ##1 o_ready && o_done; endsequence
  property p_ret; tk && (op == 6'h02 || op == 6'h34) |=> s_flush; endproperty
  a_ret: assert property (p_ret) else $error("ret len");
  property p_ld; tk && op == 6'h30 |=> o_acc == $past(i_instr[7:0]) && $stable(o_zero); endproperty
  a_ld: assert property (p_ld) else $error("ld");
  property p_st; tk && op == 6'h01 |=> o_file_we && o_file_wdata == $past(o_acc) && $stable(o_zero); endproperty
  a_st: assert property (p_st) else $error("st");
  property p_ri; tk && op == 6'h02 |=> o_gie && o_stack_pop && o_pc == $past(i_stack_top); endproperty
  a_ri: assert property (p_ri) else $error("ri");
  property p_rl; tk && op == 6'h34 |=> o_acc == $past(i_instr[7:0]) && o_pc == $past(i_stack_top); endproperty
  a_rl: assert property (p_rl) else $error("rl");
  property p_inc; tk && op == 6'h0A && !i_instr[7] |=> o_acc == 8'($past(i_file_rdata) + 8'h01); endproperty
  a_inc: assert property (p_inc) else $error("inc");
  property p_ior; tk && op == 6'h04 |=> o_zero == ((($past(o_acc)) | $past(i_file_rdata)) == 8'h00); endproperty
  a_ior: assert property (p_ior) else $error("ior");
  property p_cp; tk && op == 6'h08 && i_instr[7] |=> o_file_we && o_file_wdata == $past(i_file_rdata) && o_zero == (o_file_wdata == 8'h00); endproperty
  a_cp: assert property (p_cp) else $error("cp");
  property p_nop; tk && op == 6'h00 |=> o_pc == 13'($past(o_pc) + 13'h0001) && !o_file_we && !o_stack_pop && o_done; endproperty
  a_nop: assert property (p_nop) else $error("nop");
endmodule // ecx_monitor
bind ecx_execute ecx_monitor i_ecx_monitor (.i_clk, .i_rst_b, .i_instr_valid, .i_instr, .o_ready,
  .i_file_rdata, .o_file_we, .o_file_wdata, .i_stack_top, .o_stack_pop, .o_gie, .o_acc, .o_zero,
  .o_pc, .o_done);
`default_nettype wire

// ### tb_top.sv
// Purpose: random and directed run of ecx_execute
// Assumes: inputs driven at falling edge
// Notes:   results queued, checked on o_done
`timescale 1ns/1ps
`default_nettype none
`include "ecx_defines.vh"
module tb_top;
  reg         i_clk = 0, i_rst_b = 0, i_instr_valid = 0, i_gie_clear = 0;
  reg  [13:0] i_instr = 0;
  reg  [7:0]  i_file_rdata = 0, lf = 8'h62, acc = 0, r, wd = 0;
  reg  [12:0] i_stack_top = 0, pc = 0;
  reg         z = 0, global_interrupt_enable = 0, we = 0;
  reg  [38:0] q[$];
  integer     err_count = 0, checks_done = 0, i;
  wire        o_ready, o_file_we, o_stack_pop, o_gie, o_zero, o_done;
  wire [6:0]  o_file_raddr, o_file_waddr;
  wire [7:0]  o_file_wdata, o_acc;
  wire [12:0] o_pc;
  wire [47:0] opt = {`ECX_OPC_RETLIT, `ECX_OPC_LOADLIT, `ECX_OPC_INC, `ECX_OPC_COPY,
                     `ECX_OPC_IOR, `ECX_OPC_RETINT, `ECX_OPC_STORE, `ECX_OPC_NOP};
  ecx_execute i_ecx_execute (.i_clk, .i_rst_b, .i_instr_valid, .i_instr, .o_ready, .i_file_rdata,
    .o_file_raddr, .o_file_we, .o_file_waddr, .o_file_wdata, .i_stack_top, .o_stack_pop,
    .i_gie_clear, .o_gie, .o_acc, .o_zero, .o_pc, .o_done);
  function [7:0] nx(input [7:0] s);
    nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task run(input [2:0] n, input d, input [7:0] f);
    begin
      @(negedge i_clk);
      i_instr_valid = 1;
      i_instr = {opt[n*6 +: 6], d, lf[6:0]};
      i_file_rdata = f;
      i_stack_top = {lf[4:0], f};
      i_gie_clear = lf[7];
      #1;
      checks_done = checks_done + 1;
      if (o_file_raddr !== i_instr[6:0]) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, o_file_raddr, i_instr[6:0]);
      end
      lf = nx(lf);
      global_interrupt_enable = global_interrupt_enable & !i_gie_clear;
      pc = pc + 13'h0001;
      we = (n == 1) || (d && (n == 3 || n == 4 || n == 5));
      if (n == 1) wd = acc;
      case (n)
        3, 4, 5: begin
          r = n == 3 ? acc | f : n == 4 ? f : f + 8'h01;
          z = r == 8'h00;
          wd = r;
          if (!d) acc = r;
        end
        6, 7: acc = i_instr[7:0];
      endcase
      if (n == 2 || n == 7) pc = i_stack_top;
      if (n == 2) global_interrupt_enable = 1;
      q.push_back({acc, z, pc, global_interrupt_enable, we, i_instr[6:0], wd});
      if (n == 2 || n == 7) begin
        @(negedge i_clk);
        i_gie_clear = 0;
        i_instr = {`ECX_OPC_LOADLIT, 8'hEE};
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (o_done) begin
      checks_done = checks_done + 1;
      if (q.size() == 0) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, o_done, 1'b0);
      end else begin
        if ({o_acc, o_zero, o_pc, o_gie, o_file_we, o_file_waddr, o_file_wdata} !== q[0]) begin
          err_count = err_count + 1;
          $display("wrong value at %0t: got %h expected %h", $time,
                   {o_acc, o_zero, o_pc, o_gie, o_file_we, o_file_waddr, o_file_wdata}, q[0]);
        end
        void'(q.pop_front());
      end
    end
  initial begin
    repeat (10) @(posedge i_clk);
    @(negedge i_clk) i_rst_b = 1;
    #1;
    checks_done = checks_done + 1;
    if ({o_acc, o_zero, o_pc, o_gie, o_file_we, o_file_waddr, o_file_wdata, o_stack_pop, o_done, o_ready} !==
        {`ECX_RST_ACC, `ECX_RST_ZERO, `ECX_RST_PC, `ECX_RST_GIE, 1'b0, 7'h00, 8'h00, 3'b001}) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, {o_acc, o_zero, o_pc, o_gie},
               {`ECX_RST_ACC, `ECX_RST_ZERO, `ECX_RST_PC, `ECX_RST_GIE});
    end
    for (i = 0; i < 16; i = i + 1) run(i[2:0], i[3], i[0] ? 8'hFF : 8'h00);
    for (i = 0; i < 300; i = i + 1) run(lf[2:0], lf[3], nx(lf));
    @(negedge i_clk) i_instr_valid = 0;
    repeat (3) @(posedge i_clk);
    if (q.size() != 0) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, q.size(), 0);
    end
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
